// >>> hw/tape_drive_control_status.sv
`include "tape_drive_regs.svh"

module tape_drive_control_status
    import tape_drive_pkg::*;
#(
    parameter int STOP_CYCLES = `STOP_CYCLES,
    parameter int STATUS_BYTES = `STATUS_BYTES,
    parameter int DRIVES = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host bus side
    input wire logic [7:0] host_bus_in,
    input wire logic host_request,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    output logic host_ready,
    output logic host_ack,
    // Formatter logic side
    input wire logic cmd_load,
    input wire logic [7:0] cmd_code,
    input wire logic ctrl_load,
    input wire logic [7:0] ctrl_value,
    input wire logic alt_load,
    input wire logic [7:0] alt_value,
    input wire logic sel_load,
    input wire logic [7:0] sel_value,
    input wire logic bad_record,
    input wire logic rw_timeout,
    input wire logic count_clear,
    input wire logic flag_clear,
    input wire logic write_active,
    // Drive status pins
    input wire logic drive_offline,
    input wire logic tape_end_warning,
    // Drive outputs
    output logic buffer_flush,
    output logic flush_flag,
    output logic readout_busy,
    output logic [3:0] track_number_field,
    output logic cartridge_latch,
    output logic reverse_dir,
    output logic [DRIVES-1:0] write_current,
    output logic [DRIVES-1:0] erase_current,
    output logic [DRIVES-1:0] capstan_go,
    output logic [DRIVES-1:0] high_speed
);
    localparam int AW = $clog2(STATUS_BYTES);
    localparam int SW = $clog2(STOP_CYCLES + 1);
    localparam logic [SW-1:0] STOP_LAST = SW'(STOP_CYCLES);
    localparam logic [AW-1:0] LAST_IDX = AW'(STATUS_BYTES - 1);

    status_byte_t alt_ctrl;
    status_byte_t cmd_now;
    status_byte_t bad_count;
    status_byte_t track_drive;
    status_byte_t drive_ctrl;
    readout_state_t state;
    readout_state_t next_state;
    logic [AW-1:0] idx;
    logic [SW-1:0] stop_count;
    logic hs_sampled;
    logic [DRIVES-1:0] drive_sel;
    logic flag_set;
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [7:0] bus_s;
    logic req_s;
    logic offline_s;
    logic warn_s;

    snap_mem_if #(.AW(AW), .DW(8)) snap ();

    status_snapshot_mem #(.AW(AW), .DW(8)) u_snap (
        .sys_clk(sys_clk),
        .port(snap.mem)
    );

    // Two-stage pin synchronisers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
        end else begin
            sync1 <= {host_bus_in, host_request, drive_offline, tape_end_warning};
            sync2 <= sync1;
        end
    end
    assign bus_s = sync2[10:3];
    assign req_s = sync2[2];
    assign offline_s = sync2[1];
    assign warn_s = sync2[0];

    // Command code being executed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_now <= `RESET_BYTE;
        end else if (state == RO_IDLE && req_s && bus_s == `CMD_EXT_STATUS) begin
            cmd_now <= `CMD_EXT_STATUS;
        end else if (cmd_load) begin
            cmd_now <= cmd_code;
        end
    end

    // Alternate drive control copy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_ctrl <= `RESET_BYTE;
        end else if (alt_load) begin
            alt_ctrl <= alt_value;
        end
    end

    // Primary drive control byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_ctrl <= `RESET_BYTE;
        end else if (ctrl_load) begin
            drive_ctrl <= ctrl_value;
        end
    end

    // Track and drive select pointer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            track_drive <= `RESET_BYTE;
        end else if (sel_load) begin
            track_drive <= sel_value;
        end
    end

    // Bad record count, timeout flag on top
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bad_count <= `RESET_BYTE;
        end else begin
            if (bad_record && bad_count[6:0] != 7'h7f) begin
                bad_count[6:0] <= bad_count[6:0] + 7'h01;
            end else if (count_clear) begin
                bad_count[6:0] <= 7'h00;
            end
            if (rw_timeout) begin
                bad_count[`TIMEOUT_BIT] <= 1'b1;
            end else if (count_clear) begin
                bad_count[`TIMEOUT_BIT] <= 1'b0;
            end
        end
    end

    // offline in write or warning hole
    assign flag_set = (offline_s && write_active) || warn_s;

    // Sticky flush flag, set beats clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_flag <= 1'b0;
        end else if (flag_set) begin
            flush_flag <= 1'b1;
        end else if (flag_clear) begin
            flush_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buffer_flush <= 1'b0;
        end else begin
            buffer_flush <= flag_set && !flush_flag;
        end
    end

    assign track_number_field = 4'((track_drive & `TRACK_FIELD_MASK) >> `TRACK_FIELD_LSB);

    always_comb begin
        drive_sel = DRIVES'(track_drive & `SELECT_FIELD_MASK);
        if (!$onehot0(drive_sel)) begin
            drive_sel = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_count <= '0;
        end else if (drive_ctrl[`CTL_GO_BIT]) begin
            stop_count <= '0;
        end else if (stop_count != STOP_LAST) begin
            stop_count <= stop_count + SW'(1);
        end
    end

    // sample high speed only when stopped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_sampled <= 1'b0;
        end else if (stop_count == STOP_LAST) begin
            hs_sampled <= drive_ctrl[`CTL_HIGH_SPEED_BIT];
        end
    end

    // Drive control outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cartridge_latch <= 1'b0;
            reverse_dir <= 1'b0;
            write_current <= '0;
            erase_current <= '0;
            capstan_go <= '0;
            high_speed <= '0;
        end else begin
            cartridge_latch <= drive_ctrl[`CTL_LATCH_BIT];
            reverse_dir <= drive_ctrl[`CTL_REVERSE_BIT];
            write_current <= drive_ctrl[`CTL_WRITE_BIT] ? drive_sel : '0;
            erase_current <= drive_ctrl[`CTL_ERASE_BIT] ? drive_sel : '0;
            capstan_go <= drive_ctrl[`CTL_GO_BIT] ? drive_sel : '0;
            high_speed <= (drive_ctrl[`CTL_GO_BIT] && hs_sampled) ? drive_sel : '0;
        end
    end

    // Readout sequencer transitions
    always_comb begin
        next_state = state;
        case (state)
            RO_IDLE: begin
                if (req_s && bus_s == `CMD_EXT_STATUS) begin
                    next_state = RO_CMD_ACK;
                end
            end
            RO_CMD_ACK: begin
                if (!req_s) begin
                    next_state = RO_SNAP;
                end
            end
            RO_SNAP: begin
                if (idx == LAST_IDX) begin
                    next_state = RO_FETCH;
                end
            end
            RO_FETCH: begin
                next_state = RO_PRESENT;
            end
            RO_PRESENT: begin
                if (req_s) begin
                    next_state = RO_ACK_HI;
                end
            end
            RO_ACK_HI: begin
                if (!req_s) begin
                    next_state = (idx == LAST_IDX) ? RO_DONE : RO_FETCH;
                end
            end
            RO_DONE: begin
                next_state = RO_IDLE;
            end
            default: begin
                next_state = RO_IDLE;
            end
        endcase
    end

    // Readout state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RO_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Byte index for snapshot and readout
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= '0;
        end else if (state == RO_CMD_ACK) begin
            idx <= '0;
        end else if (state == RO_SNAP || (state == RO_ACK_HI && !req_s)) begin
            idx <= idx + AW'(1);
        end
    end

    // copy status into snapshot, read only
    always_comb begin
        snap.wr_en = (state == RO_SNAP);
        snap.wr_addr = idx;
        // Read one ahead so the registered data is ready at fetch
        snap.rd_addr = (state == RO_SNAP || state == RO_ACK_HI) ? idx + AW'(1) : idx;
        case (6'(idx))
            `OFS_WRITE_FLAGS: snap.wr_data = {7'h00, flush_flag};
            `OFS_ALT_CTRL: snap.wr_data = alt_ctrl;
            `OFS_CMD_CODE: snap.wr_data = cmd_now;
            `OFS_BAD_RECORDS: snap.wr_data = bad_count;
            `OFS_TRACK_DRIVE: snap.wr_data = track_drive;
            `OFS_DRIVE_CTRL: snap.wr_data = drive_ctrl;
            default: snap.wr_data = `RESET_BYTE;
        endcase
    end

    // present each byte on the bus
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_bus_out <= `RESET_BYTE;
        end else if (state == RO_FETCH) begin
            host_bus_out <= snap.rd_data;
        end
    end

    // Handshake outputs
    assign host_ready = (state == RO_PRESENT);
    assign host_ack = (state == RO_CMD_ACK) || (state == RO_ACK_HI);
    assign host_bus_oe = (state == RO_PRESENT) || (state == RO_ACK_HI);
    assign readout_busy = (state != RO_IDLE);
endmodule : tape_drive_control_status

// >>> pkg/tape_drive_regs.svh
`ifndef TAPE_DRIVE_REGS_SVH
`define TAPE_DRIVE_REGS_SVH

// Status byte positions
`define OFS_WRITE_FLAGS 6'h07
`define OFS_ALT_CTRL 6'h1a
`define OFS_CMD_CODE 6'h1b
`define OFS_BAD_RECORDS 6'h1c
`define OFS_TRACK_DRIVE 6'h1d
`define OFS_DRIVE_CTRL 6'h1e
`define STATUS_BYTES 64

// Drive control bit positions
`define CTL_LATCH_BIT 7
`define CTL_WRITE_BIT 6
`define CTL_ERASE_BIT 5
`define CTL_REVERSE_BIT 4
`define CTL_GO_BIT 3
`define CTL_HIGH_SPEED_BIT 2

// Select pointer fields, timeout and flush flag bits
`define TRACK_FIELD_MASK 8'hf0
`define TRACK_FIELD_LSB 4
`define SELECT_FIELD_MASK 8'h0f
`define TIMEOUT_BIT 7
`define FLUSH_FLAG_BIT 0

// Command codes and reset values
`define CMD_EXT_STATUS 8'he0
`define RESET_BYTE 8'h00

// Motion-off time before high speed is sampled
`define STOP_TIME_US 5000
`define CLK_MHZ 10
`define STOP_CYCLES (`STOP_TIME_US * `CLK_MHZ)

`endif

// >>> pkg/tape_drive_pkg.sv
package tape_drive_pkg;
    typedef logic [7:0] status_byte_t;

    typedef enum logic [2:0] {
        RO_IDLE,
        RO_CMD_ACK,
        RO_SNAP,
        RO_FETCH,
        RO_PRESENT,
        RO_ACK_HI,
        RO_DONE
    } readout_state_t;
endpackage : tape_drive_pkg

// >>> pkg/snap_mem_if.sv
interface snap_mem_if #(parameter int AW = 6, parameter int DW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : snap_mem_if

// >>> hw/status_snapshot_mem.sv
module status_snapshot_mem #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    input wire logic sys_clk,
    snap_mem_if.mem port
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    // Snapshot write port
    always_ff @(posedge sys_clk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk) begin
        port.rd_data <= store[port.rd_addr];
    end
endmodule : status_snapshot_mem

// >>> verif/tape_drive_monitor.sv
module tape_drive_monitor #(
    parameter int DRIVES = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ctrl_load,
    input wire logic [7:0] ctrl_value,
    input wire logic flush_flag,
    input wire logic buffer_flush,
    input wire logic cartridge_latch,
    input wire logic reverse_dir,
    input wire logic [DRIVES-1:0] write_current,
    input wire logic [DRIVES-1:0] capstan_go,
    input wire logic [DRIVES-1:0] high_speed,
    input wire logic host_ready,
    input wire logic host_bus_oe,
    input wire logic readout_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctrl_q1;
    logic [7:0] ctrl_q2;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Loaded control byte two edges back
    always_ff @(posedge sys_clk) begin
        ctrl_q1 <= ctrl_value;
        ctrl_q2 <= ctrl_q1;
    end

    flush_pulse_a: assert property ($rose(flush_flag) |-> buffer_flush)
        else $error("flush pulse missing on flag rise");
    pulse_single_a: assert property (buffer_flush |-> flush_flag ##1 !buffer_flush)
        else $error("flush pulse malformed");
    latch_load_a: assert property (ctrl_load |-> ##2 cartridge_latch == ctrl_q2[7])
        else $error("latch does not follow control byte");
    dir_load_a: assert property (ctrl_load |-> ##2 reverse_dir == ctrl_q2[4])
        else $error("direction does not follow control byte");
    one_drive_a: assert property ($onehot0(capstan_go) && $onehot0(write_current))
        else $error("more than one drive active");
    speed_go_a: assert property ((high_speed & ~capstan_go) == '0)
        else $error("high speed without motion");
    hold_still_a: assert property (!ctrl_load |-> ##2 $stable({cartridge_latch, reverse_dir}))
        else $error("control output changed without a load");
    ready_oe_a: assert property (host_ready |-> host_bus_oe && readout_busy)
        else $error("ready without bus drive");

    cover property (buffer_flush);
    cover property (|high_speed);
    cover property ($rose(readout_busy));
    cover property (|write_current);
endmodule : tape_drive_monitor

// >>> verif/tape_drive_model.sv
module tape_drive_model #(
    parameter int LIMIT = 200
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] capstan_go,
    input wire logic reverse_dir,
    input wire logic go_offline,
    output logic drive_offline,
    output logic tape_end_warning
);
    timeunit 1ns;
    timeprecision 1ns;
    int pos;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pos <= 0;
        else if (|capstan_go) pos <= reverse_dir ? pos - 1 : pos + 1;
    end

    assign tape_end_warning = pos >= LIMIT;
    assign drive_offline = go_offline;
endmodule : tape_drive_model

// >>> verif/testbench.sv
module testbench
    import tape_drive_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_n, host_request, cmd_load, ctrl_load, alt_load, sel_load;
    logic bad_record, rw_timeout, count_clear, flag_clear, write_active, go_offline, rdy_q = 1'b0;
    logic [7:0] host_bus_in, cmd_code, ctrl_value, alt_value, sel_value, host_bus_out, c, s, a;
    logic host_bus_oe, host_ready, host_ack, buffer_flush, flush_flag, readout_busy;
    logic cartridge_latch, reverse_dir, drive_offline, tape_end_warning, h;
    logic [3:0] track_number_field, write_current, erase_current, capstan_go, high_speed;
    logic [3:0] sels [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    logic [17:0] outs;
    logic [31:0] seed = 32'hc336;
    int miscompares = 0, checked = 0;
    status_byte_t exp_q[$];

    tape_drive_control_status #(.STOP_CYCLES(8)) tape_drive_control_status_inst (.sys_clk,
        .rst_n, .host_bus_in, .host_request, .host_bus_out, .host_bus_oe, .host_ready, .host_ack,
        .cmd_load, .cmd_code, .ctrl_load, .ctrl_value, .alt_load, .alt_value, .sel_load,
        .sel_value, .bad_record, .rw_timeout, .count_clear, .flag_clear, .write_active,
        .drive_offline, .tape_end_warning, .buffer_flush, .flush_flag, .readout_busy,
        .track_number_field, .cartridge_latch, .reverse_dir, .write_current, .erase_current,
        .capstan_go, .high_speed);
    tape_drive_model tape_drive_model_inst (.sys_clk, .rst_n, .capstan_go, .reverse_dir,
        .go_offline, .drive_offline, .tape_end_warning);

    assign outs = {cartridge_latch, reverse_dir, write_current, erase_current, capstan_go,
        high_speed};
    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Drive outputs expected from control byte, pointer and latched speed
    function automatic logic [17:0] exp_out(logic [7:0] cv, logic [7:0] sv, logic hv);
        logic [3:0] d;
        d = $onehot(sv[3:0]) ? sv[3:0] : 4'h0;
        return {cv[7], cv[4], cv[6] ? d : 4'h0, cv[5] ? d : 4'h0, cv[3] ? d : 4'h0,
            (cv[3] & hv) ? d : 4'h0};
    endfunction : exp_out

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : cyc

    task automatic fail(input string m);
        miscompares++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail

    task automatic chk_out(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) fail("output mismatch");
    endtask : chk_out

    task automatic chk_byte(input status_byte_t got, input status_byte_t exp);
        checked++;
        if (got !== exp) fail("status byte mismatch");
    endtask : chk_byte

    task automatic results();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    function automatic logic cond(input int k);
        case (k)
            0: return host_ack;
            1: return !host_ack;
            2: return host_ready;
            3: return !host_ready && host_ack;
            default: return flush_flag;
        endcase
    endfunction : cond

    task automatic await(input int k, input int lim);
        int i;
        i = 0;
        while (cond(k) !== 1'b1 && i < lim) begin
            cyc(1);
            i++;
        end
        if (i >= lim) begin
            fail("wait timed out");
            results();
        end
    endtask : await

    task automatic load(input int k, input logic [7:0] v);
        case (k)
            0: {ctrl_value, ctrl_load} = {v, 1'b1};
            1: {sel_value, sel_load} = {v, 1'b1};
            2: {alt_value, alt_load} = {v, 1'b1};
            default: {cmd_code, cmd_load} = {v, 1'b1};
        endcase
        cyc(1);
        case (k)
            0: ctrl_load = 1'b0;
            1: sel_load = 1'b0;
            2: alt_load = 1'b0;
            default: cmd_load = 1'b0;
        endcase
    endtask : load

    // Byte watcher takes the oldest expected byte as each byte is offered
    always @(posedge sys_clk) begin
        rdy_q <= host_ready;
        if (host_ready === 1'b1 && rdy_q !== 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected byte");
            else chk_byte(host_bus_out, exp_q.pop_front());
        end
    end

    task automatic readout(input logic [7:0] cnt);
        for (int i = 0; i < 64; i++) begin
            exp_q.push_back(i == 26 ? a : i == 27 ? 8'he0 : i == 28 ? cnt : i == 29 ? s :
                i == 30 ? c : 8'h00);
        end
        {host_bus_in, host_request} = {8'he0, 1'b1};
        await(0, 20);
        host_request = 1'b0;
        await(1, 20);
        for (int i = 0; i < 64; i++) begin
            await(2, 200);
            host_request = 1'b1;
            await(3, 20);
            host_request = 1'b0;
            await(1, 20);
        end
        cyc(4);
        chk_out(18'(exp_q.size()), 18'h0);
    endtask : readout

    initial begin
        {rst_n, host_request, cmd_load, ctrl_load, alt_load, sel_load, bad_record} = 7'h0;
        {rw_timeout, count_clear, flag_clear, write_active, go_offline} = 5'h0;
        {host_bus_in, cmd_code, ctrl_value, alt_value, sel_value} = 40'h0;
        cyc(8);
        rst_n = 1'b1;
        cyc(1);
        chk_out(outs, 18'h0);
        for (int k = 0; k < 5; k++) begin
            c = 8'(rnd()) & 8'hf7;
            h = c[2];
            s = {c[5] ? 4'h0 : 4'(rnd()), sels[k]};
            load(1, s);
            load(0, c);
            cyc(12);
            chk_out(outs, exp_out(c, s, h));
            chk_out(18'(track_number_field), 18'(s[7:4]));
            c = c | 8'h08;
            load(0, c);
            cyc(3);
            chk_out(outs, exp_out(c, s, h));
            c = c ^ 8'h04;
            load(0, c);
            cyc(3);
            chk_out(outs, exp_out(c, s, h));
        end
        $display("drive control test done");
        load(0, 8'h00);
        go_offline = 1'b1;
        cyc(6);
        chk_out(18'(flush_flag), 18'h0);
        write_active = 1'b1;
        await(4, 10);
        chk_out(18'(buffer_flush), 18'h1);
        {go_offline, write_active} = 2'b00;
        cyc(3);
        flag_clear = 1'b1;
        cyc(1);
        flag_clear = 1'b0;
        cyc(1);
        chk_out(18'(flush_flag), 18'h0);
        $display("offline flush test done");
        a = 8'(rnd());
        c = 8'(rnd()) & 8'hd3;
        s = (8'(rnd()) & 8'hf0) | 8'h02;
        load(2, a);
        load(3, 8'(rnd()));
        load(0, c);
        load(1, s);
        bad_record = 1'b1;
        cyc(3);
        {bad_record, rw_timeout} = 2'b01;
        cyc(1);
        rw_timeout = 1'b0;
        {host_bus_in, host_request} = {8'(rnd()) | 8'h01, 1'b1};
        cyc(10);
        chk_out(18'(host_ack), 18'h0);
        host_request = 1'b0;
        cyc(4);
        readout(8'h83);
        chk_out(outs, exp_out(c, s, 1'b0));
        $display("readout test done");
        load(1, 8'h01);
        load(0, 8'h08);
        await(4, 300);
        rst_n = 1'b0;
        cyc(3);
        chk_out(outs | 18'(flush_flag), 18'h0);
        rst_n = 1'b1;
        cyc(2);
        $display("tape end test done");
        results();
    end
endmodule : testbench

bind tape_drive_control_status tape_drive_monitor #(.DRIVES(DRIVES)) tape_drive_monitor_inst (
    .sys_clk, .rst_n, .ctrl_load, .ctrl_value, .flush_flag, .buffer_flush, .cartridge_latch,
    .reverse_dir, .write_current, .capstan_go, .high_speed, .host_ready, .host_bus_oe,
    .readout_busy);
